/* rtl/suc_cfg.svh */
// timing and reset constants for the serial character core
// assumes a 10 MHz system clock
`ifndef SUC_CFG_SVH
`define SUC_CFG_SVH
`define SUC_CLK_HZ          10000000
`define SUC_BAUD_HZ         115200
`define SUC_DIV_DEFAULT     ((`SUC_CLK_HZ / `SUC_BAUD_HZ) - 1)
`define SUC_REG_W           16
`define SUC_LINE_IDLE       1'b0
`define SUC_LINE_ACTIVE     1'b1
`endif

/* rtl/suc_core.sv */
// serial character core: transmitter, receiver, baud divider, status
// assumes synchronous inputs on clk; register access via strobe ports
// Functional notes
// - 16-bit divisor and character-wide end-of-packet registers reachable by strobes
// - active-high interrupt on rx ready/tx accept
// - ready/valid flow control for stream masters
// - mark is 0, space is 1
// - 7/8/9 bit holding and shift registers
// - shift out lsb first
// - transmitter double buffered
// - tx ready, shift empty, overrun status
// - start, parity, stop bits added
// - rx holding loads on complete character
// - receiver double buffered
// - framing, parity, overrun, break flags
// - baud clock divided from system clock
// - divisor constant or software register
// - fixed divisor when register omitted
// - cts/rts pins only with flow control
// - baud equals clock over divisor plus one
// - even/odd parity bit values
// - send 1/2 stops, receive checks first
// - cts/rts only touch status/control bits
`timescale 1ns/1ps
`include "suc_cfg.svh"
module suc_core #(
    parameter int          DATA_BITS = 8,
    parameter int          STOP_BITS = 1,
    parameter suc_pkg::suc_par_e PARITY = suc_pkg::SUC_PAR_NONE,
    parameter bit          VAR_DIV   = 1'b1,
    parameter bit          FLOW_CTRL = 1'b1,
    parameter logic [15:0] DIV_INIT  = 16'(`SUC_DIV_DEFAULT)
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [DATA_BITS-1:0]  tx_data,
    input  wire logic                  tx_valid,
    output logic                       tx_ready,
    output logic [DATA_BITS-1:0]       rx_data,
    output logic                       rx_valid,
    input  wire logic                  rx_take,
    input  wire logic                  div_wr,
    input  wire logic [15:0]           div_wdata,
    output logic [15:0]                div_rdata,
    input  wire logic [DATA_BITS-1:0]  eop_wdata,
    input  wire logic                  eop_wr,
    output logic [DATA_BITS-1:0]       eop_rdata,
    input  wire logic                  status_clr,
    output suc_pkg::suc_status_s       status,
    input  wire logic                  irq_en_rx,
    input  wire logic                  irq_en_tx,
    output logic                       irq,
    input  wire logic                  rts_ctl,
    output logic                       rts_n,
    input  wire logic                  cts_n,
    input  wire logic                  rxd,
    output logic                       txd
);
    import suc_pkg::*;

    localparam int PAR_BITS = (PARITY == SUC_PAR_NONE) ? 0 : 1;
    localparam int FRAME    = 1 + DATA_BITS + PAR_BITS + STOP_BITS;
    localparam int RX_BITS  = DATA_BITS + PAR_BITS;

    typedef enum logic [1:0] {SUC_IDLE, SUC_SHIFT} suc_tx_e;
    typedef enum logic [1:0] {SUC_RWAIT, SUC_RSTART, SUC_RDATA, SUC_RSTOP} suc_rx_e;

    logic [15:0]          div_r;
    logic [15:0]          tx_cnt_r;
    logic [15:0]          rx_cnt_r;
    logic [DATA_BITS-1:0] thr_r;
    logic                 thr_full_r;
    logic [11:0]          tsr_r;
    logic [3:0]           tx_left_r;
    suc_tx_e              tx_st_r;
    logic                 tx_tick;
    logic [RX_BITS-1:0]   rsr_r;
    logic [3:0]           rx_idx_r;
    suc_rx_e              rx_st_r;
    logic                 rx_tick;
    logic                 rx_done;
    logic                 rx_par_bad;
    logic [4:0]           space_cnt_r;
    logic                 cts_d_r;
    logic                 tx_ovr_r;
    logic                 rx_ovr_r;
    logic                 brk_r;
    logic                 pe_r;
    logic                 fe_r;
    logic [DATA_BITS-1:0] eop_r;
    logic [DATA_BITS-1:0] tx_par_src;
    logic                 tx_par;

    // divisor register or fixed constant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= DIV_INIT;
        end else if (VAR_DIV && div_wr) begin
            div_r <= div_wdata;
        end
    end
    assign div_rdata = VAR_DIV ? div_r : DIV_INIT;

    // baud ticks: one per divisor+1 clocks
    assign tx_tick = (tx_cnt_r == 16'h0000);
    assign rx_tick = (rx_cnt_r == 16'h0000);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_cnt_r <= 16'h0000;
        end else if (tx_tick || tx_st_r == SUC_IDLE) begin
            tx_cnt_r <= div_rdata;
        end else begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end
    end

    // parity of the outgoing character
    assign tx_par_src = thr_r;
    assign tx_par     = (^tx_par_src) ^ (PARITY == SUC_PAR_ODD);

    // transmit holding register, double buffered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thr_r      <= '0;
            thr_full_r <= 1'b0;
        end else if (tx_valid && !thr_full_r) begin
            thr_r      <= tx_data;
            thr_full_r <= 1'b1;
        end else if (tx_st_r == SUC_IDLE && thr_full_r) begin
            thr_full_r <= 1'b0;
        end
    end

    // shift register: start, data lsb first, parity, stops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tsr_r     <= '0;
            tx_left_r <= 4'h0;
            tx_st_r   <= SUC_IDLE;
        end else begin
            unique case (tx_st_r)
                SUC_IDLE: begin
                    if (thr_full_r) begin
                        tsr_r <= 12'({{STOP_BITS{`SUC_LINE_IDLE}},
                                      (PAR_BITS != 0) ? tx_par : `SUC_LINE_IDLE, thr_r,
                                      `SUC_LINE_ACTIVE})
                                 >> (PAR_BITS == 0 ? 0 : 0);
                        if (PAR_BITS == 0) begin
                            tsr_r <= 12'({{STOP_BITS{`SUC_LINE_IDLE}}, thr_r, `SUC_LINE_ACTIVE});
                        end
                        tx_left_r <= 4'(FRAME);
                        tx_st_r   <= SUC_SHIFT;
                    end
                end
                SUC_SHIFT: begin
                    if (tx_tick) begin
                        tsr_r     <= {`SUC_LINE_IDLE, tsr_r[11:1]};
                        tx_left_r <= tx_left_r - 4'h1;
                        if (tx_left_r == 4'h1) begin
                            tx_st_r <= SUC_IDLE;
                        end
                    end
                end
                default: tx_st_r <= SUC_IDLE;
            endcase
        end
    end

    // serial output registered from the shift register, held at idle outside shifting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txd <= `SUC_LINE_IDLE;
        end else begin
            txd <= (tx_st_r == SUC_SHIFT) ? tsr_r[0] : `SUC_LINE_IDLE;
        end
    end

    // receive baud counter, restarted at half a bit on start edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_cnt_r <= 16'h0000;
        end else if (rx_st_r == SUC_RWAIT) begin
            rx_cnt_r <= {1'b0, div_rdata[15:1]};
        end else if (rx_tick) begin
            rx_cnt_r <= div_rdata;
        end else begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
        end
    end

    // receiver state machine
    assign rx_done    = (rx_st_r == SUC_RSTOP) && rx_tick;
    assign rx_par_bad = (PAR_BITS != 0) &&
                        ((^rsr_r) != (PARITY == SUC_PAR_ODD));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rsr_r    <= '0;
            rx_idx_r <= 4'h0;
            rx_st_r  <= SUC_RWAIT;
        end else begin
            unique case (rx_st_r)
                SUC_RWAIT: begin
                    if (rxd == `SUC_LINE_ACTIVE) begin
                        rx_st_r <= SUC_RSTART;
                    end
                end
                SUC_RSTART: begin
                    if (rx_tick) begin
                        rx_idx_r <= 4'h0;
                        rx_st_r  <= (rxd == `SUC_LINE_ACTIVE) ? SUC_RDATA : SUC_RWAIT;
                    end
                end
                SUC_RDATA: begin
                    if (rx_tick) begin
                        rsr_r    <= {rxd, rsr_r[RX_BITS-1:1]}; // lsb arrives first
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == 4'(RX_BITS - 1)) begin
                            rx_st_r <= SUC_RSTOP;
                        end
                    end
                end
                SUC_RSTOP: begin
                    if (rx_tick) begin
                        rx_st_r <= SUC_RWAIT;
                    end
                end
                default: rx_st_r <= SUC_RWAIT;
            endcase
        end
    end

    // receive holding register and ready flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_data  <= '0;
            rx_valid <= 1'b0;
        end else if (rx_done) begin
            rx_data  <= rsr_r[DATA_BITS-1:0];
            rx_valid <= 1'b1;
        end else if (rx_take) begin
            rx_valid <= 1'b0;
        end
    end

    // space-level run length for break detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            space_cnt_r <= 5'h00;
        end else if (rxd != `SUC_LINE_ACTIVE) begin
            space_cnt_r <= 5'h00;
        end else if (rx_tick && space_cnt_r != 5'h1F) begin
            space_cnt_r <= space_cnt_r + 5'h01;
        end
    end

    // sticky error flags; a new event wins over a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ovr_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            brk_r    <= 1'b0;
            pe_r     <= 1'b0;
            fe_r     <= 1'b0;
        end else begin
            tx_ovr_r <= (tx_valid && thr_full_r) | (tx_ovr_r & ~status_clr);
            rx_ovr_r <= (rx_done && rx_valid && !rx_take) | (rx_ovr_r & ~status_clr);
            brk_r    <= (space_cnt_r >= 5'(FRAME)) | (brk_r & ~status_clr);
            pe_r     <= (rx_done && rx_par_bad) | (pe_r & ~status_clr);
            fe_r     <= (rx_done && rxd != `SUC_LINE_IDLE) | (fe_r & ~status_clr);
        end
    end

    // end-of-packet character store
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eop_r <= '0;
        end else if (eop_wr) begin
            eop_r <= eop_wdata;
        end
    end
    assign eop_rdata = eop_r;

    // flow-control pins tied only to status and control bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cts_d_r <= 1'b0;
            rts_n   <= 1'b1;
        end else begin
            cts_d_r <= FLOW_CTRL ? ~cts_n : 1'b0;
            rts_n   <= FLOW_CTRL ? ~rts_ctl : 1'b1;
        end
    end

    // status word, ready and interrupt outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status   <= '0;
            tx_ready <= 1'b0;
            irq      <= 1'b0;
        end else begin
            tx_ready                  <= !thr_full_r && !tx_valid;
            status.tx_can_accept      <= !thr_full_r;
            status.tx_shift_empty     <= (tx_st_r == SUC_IDLE) && !thr_full_r;
            status.tx_overrun         <= tx_ovr_r;
            status.rx_ready           <= rx_valid;
            status.rx_overrun         <= rx_ovr_r;
            status.line_break_flag    <= brk_r;
            status.parity_fault_flag  <= pe_r;
            status.framing_fault_flag <= fe_r;
            status.cts                <= cts_d_r;
            status.dcts               <= FLOW_CTRL && (cts_d_r != ~cts_n);
            irq <= (irq_en_rx && rx_valid) || (irq_en_tx && !thr_full_r);
        end
    end

endmodule

/* rtl/suc_pkg.sv */
// types shared by the serial character core
// assumes the cfg header is included by users of the constants
package suc_pkg;
    typedef enum logic [1:0] {SUC_PAR_NONE, SUC_PAR_EVEN, SUC_PAR_ODD} suc_par_e;
    typedef struct packed {
        logic tx_can_accept;
        logic tx_shift_empty;
        logic tx_overrun;
        logic rx_ready;
        logic rx_overrun;
        logic line_break_flag;
        logic parity_fault_flag;
        logic framing_fault_flag;
        logic cts;
        logic dcts;
    } suc_status_s;
endpackage

/* tb/suc_core_chk.sv */
// port checker for the serial character core
// assumes one clock domain and the status struct of suc_pkg
`timescale 1ns/1ps
module suc_core_chk (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                tx_valid,
    input wire logic                tx_ready,
    input wire logic                rx_valid,
    input wire logic                rx_take,
    input wire logic                div_wr,
    input wire logic [15:0]         div_wdata,
    input wire logic [15:0]         div_rdata,
    input wire logic                status_clr,
    input wire suc_pkg::suc_status_s status,
    input wire logic                irq_en_rx,
    input wire logic                irq_en_tx,
    input wire logic                irq,
    input wire logic                rts_ctl,
    input wire logic                rts_n
);
    import suc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // transmit side
    chk_take_fills: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("slot still free after a take");
    chk_tx_refused: assert property (tx_valid && !tx_ready |-> ##2 status.tx_overrun)
        else $error("refused write left no overrun");
    chk_ovr_clear: assert property (status_clr && !tx_valid |-> ##2 !status.tx_overrun)
        else $error("overrun not cleared");
    // receive side and interrupt
    chk_rx_stands: assert property (rx_valid && !rx_take |=> rx_valid)
        else $error("char lost before take");
    chk_fe_sticky: assert property (status.framing_fault_flag && !$past(status_clr) |=> status.framing_fault_flag)
        else $error("framing flag dropped");
    chk_irq_rx: assert property ($rose(rx_valid) && irq_en_rx |-> ##[0:2] irq)
        else $error("no irq for received char");
    chk_irq_off: assert property ((!irq_en_rx && !irq_en_tx) [*2] |-> !irq)
        else $error("irq while disabled");
    // divisor and flow pins
    chk_div_write: assert property (div_wr |=> div_rdata == $past(div_wdata))
        else $error("divisor not written");
    chk_rts_follow: assert property ($past(nrst) |-> rts_n == !$past(rts_ctl))
        else $error("rts pin not following control");
    cover property (tx_valid && tx_ready);
    cover property ($rose(rx_valid));
    cover property ($rose(status.line_break_flag));
endmodule
bind suc_core suc_core_chk chk_u (.clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_take(rx_take), .div_wr(div_wr), .div_wdata(div_wdata), .div_rdata(div_rdata),
    .status_clr(status_clr), .status(status), .irq_en_rx(irq_en_rx), .irq_en_tx(irq_en_tx), .irq(irq),
    .rts_ctl(rts_ctl), .rts_n(rts_n));

/* tb/suc_core_tb.sv */
// self-checking bench for the serial character core with a far-end model
// assumes divisor 3 at reset, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module suc_core_tb;
    import suc_pkg::*;
    logic clk = 0, nrst = 0, tx_valid = 0, rx_take = 0, div_wr = 0, status_clr = 0, eop_wr = 0;
    logic irq_en_rx = 0, irq_en_tx = 0, rts_ctl = 0, cts_n = 1, tx_ready, rx_valid, irq, rts_n, rxd, txd;
    logic [7:0] tx_data = 8'h00, rx_data, r, eop_wdata = 8'h00, eop_rdata;
    logic [15:0] div_wdata = 16'h0003, div_rdata;
    suc_status_s status;
    int fails = 0, n_checks = 0;
    logic [7:0] exp_q[$];  // model of characters due on the wire
    suc_core #(.DIV_INIT(16'h0003)) dut_u (.clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_take(rx_take), .div_wr(div_wr),
        .div_wdata(div_wdata), .div_rdata(div_rdata), .eop_wdata(eop_wdata), .eop_wr(eop_wr), .eop_rdata(eop_rdata),
        .status_clr(status_clr), .status(status), .irq_en_rx(irq_en_rx), .irq_en_tx(irq_en_tx), .irq(irq),
        .rts_ctl(rts_ctl), .rts_n(rts_n), .cts_n(cts_n), .rxd(rxd), .txd(txd));
    suc_far far_u (.clk(clk), .txd(txd), .rxd(rxd));
    always #50 clk = ~clk;
    task automatic cmp_bit(input logic g, input logic e, input string m);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic cmp_char(input logic [7:0] g, input logic [7:0] e, input string m);
        cmp_bit(g === e, 1'b1, m);
    endtask
    // offer one char once the slot is free
    task automatic put(input logic [7:0] d);
        @(negedge clk);
        for (int k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= d;
        @(posedge clk);
        tx_valid <= 1'b0;
        exp_q.push_back(d);
    endtask
    task automatic pulse_clr;
        @(posedge clk);
        status_clr <= 1'b1;
        rx_take <= 1'b1;
        @(posedge clk);
        status_clr <= 1'b0;
        rx_take <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // compare every char the far end decoded against the model
    task automatic wire_check;
        for (int k = 0; k < 9000 && far_u.got.size() < exp_q.size(); k++) @(posedge clk);
        cmp_bit(far_u.got.size() == exp_q.size(), 1'b1, "wire char count");
        foreach (exp_q[i]) cmp_char(far_u.got[i], exp_q[i], "wire char");
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #5000000;
        fails++;
        close_out();
    end
    // main sequence
    initial begin
        void'($urandom(67905));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(negedge clk);
        cmp_bit(tx_ready, 1'b1, "slot free after reset");
        cmp_bit(txd, 1'b0, "line idles at mark");
        for (int i = 0; i < 4; i++) put(8'($urandom));
        @(posedge clk);
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        repeat (2) @(negedge clk);
        cmp_bit(status.tx_overrun, 1'b1, "overrun on full slot");
        cmp_bit(status.tx_can_accept, 1'b0, "holding register full");
        pulse_clr();
        cmp_bit(status.tx_overrun, 1'b0, "overrun cleared");
        wire_check();
        irq_en_tx <= 1'b1;
        repeat (3) @(negedge clk);
        cmp_bit(irq, 1'b1, "irq for free slot");
        cmp_bit(status.tx_shift_empty, 1'b1, "shift register empty");
        @(posedge clk);
        irq_en_tx <= 1'b0;
        irq_en_rx <= 1'b1;
        $display("test transmit done");
        for (int i = 0; i < 3; i++) begin
            r = 8'($urandom);
            far_u.send(r, 1'b0);
            repeat (2) @(negedge clk);
            cmp_bit(rx_valid, 1'b1, "char received");
            cmp_char(rx_data, r, "rx char");
            cmp_bit(irq, 1'b1, "irq for received char");
            pulse_clr();
            cmp_bit(rx_valid, 1'b0, "char taken");
        end
        far_u.send(8'($urandom), 1'b0);
        far_u.send(8'($urandom), 1'b0);
        repeat (2) @(negedge clk);
        cmp_bit(status.rx_overrun, 1'b1, "unread char overrun");
        pulse_clr();
        $display("test receive done");
        @(posedge clk);
        div_wdata <= 16'h0007;
        div_wr <= 1'b1;
        @(posedge clk);
        div_wr <= 1'b0;
        far_u.bitc = 8;
        @(negedge clk);
        cmp_bit(div_rdata === 16'h0007, 1'b1, "divisor readback");
        put(8'($urandom));
        wire_check();
        $display("test divisor done");
        far_u.send(8'($urandom), 1'b1);
        repeat (2) @(negedge clk);
        cmp_bit(status.framing_fault_flag, 1'b1, "bad stop bit");
        cmp_bit(status.parity_fault_flag, 1'b0, "no parity fault without parity");
        repeat (200) @(posedge clk);
        pulse_clr();
        far_u.send(8'hFF, 1'b1);
        far_u.send(8'hFF, 1'b1);
        repeat (2) @(negedge clk);
        cmp_bit(status.line_break_flag, 1'b1, "break on held space");
        $display("test faults done");
        @(posedge clk);
        rts_ctl <= 1'b1;
        cts_n <= 1'b0;
        eop_wdata <= 8'($urandom);
        eop_wr <= 1'b1;
        @(posedge clk);
        eop_wr <= 1'b0;
        repeat (4) @(negedge clk);
        cmp_char(eop_rdata, eop_wdata, "end-of-packet store");
        cmp_bit(status.dcts, 1'b0, "cts change pulse over");
        cmp_bit(rts_n, 1'b0, "rts pin follows control");
        cmp_bit(status.cts, 1'b1, "cts seen in status");
        $display("test flow pins done");
        close_out();
    end
endmodule

/* tb/suc_far.sv */
// far-end serial device: sends frames on rxd, decodes frames seen on txd
// assumes the core's clk, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module suc_far (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    int         bitc = 4;  // clocks per bit, divisor plus one
    logic [7:0] got[$];    // characters decoded from txd
    logic [7:0] c;
    initial rxd = 1'b0;
    // one frame: start at space, data lsb first, stop level stp
    task automatic send(input logic [7:0] d, input logic stp);
        @(posedge clk);
        rxd <= 1'b1;
        repeat (bitc) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= d[i];
            repeat (bitc) @(posedge clk);
        end
        rxd <= stp;
        repeat (bitc) @(posedge clk);
        rxd <= 1'b0;
    endtask
    // decode at mid bit, keep only frames with a mark stop bit
    always begin
        @(posedge txd);
        repeat (bitc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(posedge clk);
            c[i] = txd;
        end
        repeat (bitc) @(posedge clk);
        if (txd === 1'b0) got.push_back(c);
    end
endmodule
